// file: design/smcd_defines.svh
/*
 Constants for the stepper motion command decoder: frame bytes,
 command codes, frame lengths and setting reset values.
 Assumes inclusion by bare name from both ends of the link.
*/
`ifndef SMCD_DEFINES_SVH
`define SMCD_DEFINES_SVH
// ==========================================================
// Address byte layout
`define SMCD_ADDR_TOP 2'h3
`define SMCD_ADDR_TOP_HI 7
`define SMCD_ADDR_TOP_LO 6
`define SMCD_ADDR_NODE_HI 5
`define SMCD_ADDR_NODE_LO 2
`define SMCD_ADDR_PIN_BIT 1
`define SMCD_ADDR_RW_BIT 0
// Broadcast node bits, reaching all motor nodes with the addressed pin bit; only the safe command acts on a broadcast
`define SMCD_BCAST_NODE 4'h0
// ==========================================================
// Command codes
`define SMCD_CMD_SAFE 8'h84
`define SMCD_CMD_STOP 8'h85
`define SMCD_CMD_ZERO 8'h86
`define SMCD_CMD_RELOAD 8'h87
`define SMCD_CMD_RUN 8'h97
`define SMCD_CMD_DUAL 8'h88
`define SMCD_CMD_PARAM 8'h89
`define SMCD_CMD_FUSE 8'h90
`define SMCD_FILL 8'hff
// ==========================================================
// Frame lengths in bytes, address included
`define SMCD_LEN_SHORT 4'h2
`define SMCD_LEN_FUSE 4'h6
`define SMCD_LEN_LONG 4'h9
// ==========================================================
// Motion-setting reset values
`define SMCD_RST_IRUN 4'h0
`define SMCD_RST_IHOLD 4'h0
`define SMCD_RST_VMAX 4'h0
`define SMCD_RST_VMIN 4'h0
`define SMCD_RST_SAFE 11'h400
`define SMCD_RST_DIR 1'b0
`define SMCD_RST_ACC 4'h0
`define SMCD_RST_RAMP 1'b0
`define SMCD_RST_STEP 2'h0
`endif

// file: design/smcd_pkg.sv
/*
 Types used by the device end of the stepper motion command decoder and by the bench.
 Assumes smcd_defines.svh is available to the same compile.
*/
package smcd_pkg;
   // Motion state shown by the device
   typedef enum logic [2:0] {
      SMCD_IDLE,
      SMCD_MOVE,
      SMCD_RUN,
      SMCD_DUAL1,
      SMCD_DUAL2,
      SMCD_SHUT
   } smcd_motion_t;
endpackage

// file: design/smcd_link_if.sv
/*
 Byte link between bus controller end and device end.
 Assumes one clock; a frame is a run of byte strobes ended by frame_end.
*/
`timescale 1ns/1ps
interface smcd_link_if;
   logic byte_valid; // One-cycle byte strobe
   logic [7:0] byte_data; // Byte carried by the strobe
   logic frame_end; // One-cycle end-of-frame pulse
   // Controller end drives the bytes
   modport ctrl (output byte_valid, output byte_data, output frame_end);
   // Device end receives them
   modport dev (input byte_valid, input byte_data, input frame_end);
endinterface

// file: design/smcd_device.sv
/*
 Device end: collects command frames, decodes them and keeps the
 positions, motion settings, motion state and missed-step flag.
 Assumes byte link synchronous to clk; fault and motion-done inputs
 come from the coil drivers and position controller.
*/
`timescale 1ns/1ps
`include "smcd_defines.svh"
module smcd_device (
   input wire logic clk,
   input wire logic rst_b,
   smcd_link_if.dev link,
   input wire logic [3:0] node_addr, // Fuse node address bits
   input wire logic pin_address_bit, // Hardwired address pin
   input wire logic coil_fault, // Electrical fault on either coil
   input wire logic motion_done, // Controller reports target reached
   input wire logic clear_missed, // First status read clears the flag
   input wire logic [15:0] actual_in, // Position controller step count
   input wire logic actual_load, // Pulse: take actual_in
   output logic [15:0] actual_position,
   output logic [15:0] target_position,
   output logic missed_steps_flag,
   output smcd_pkg::smcd_motion_t motion_state,
   output logic [3:0] run_current,
   output logic [3:0] hold_current,
   output logic [3:0] max_velocity,
   output logic [3:0] min_velocity,
   output logic [10:0] safe_position,
   output logic move_direction,
   output logic [3:0] acceleration,
   output logic ramp_disable,
   output logic [1:0] step_resolution,
   output logic [15:0] second_offset,
   output logic fuse_write,
   output logic [2:0] fuse_cell_address,
   output logic [7:0] fuse_data
);
   // ==========================================================
   // Frame capture
   logic [7:0] frame_reg [0:8]; // Received bytes of the frame
   logic [3:0] count_reg; // Bytes received so far
   logic addr_ok; // Address byte matches this node
   logic bcast; // Address byte is a broadcast
   logic [7:0] cmd; // Command byte
   logic go; // Frame accepted this cycle
   logic moving; // Motor in motion
   logic [15:0] first_target; // Dual move first target

   assign cmd = frame_reg[1];
   assign moving = motion_state != smcd_pkg::SMCD_IDLE && motion_state != smcd_pkg::SMCD_SHUT;
   // Address check, write direction
   assign bcast = frame_reg[0][`SMCD_ADDR_NODE_HI:`SMCD_ADDR_NODE_LO] == `SMCD_BCAST_NODE;
   assign addr_ok = frame_reg[0][`SMCD_ADDR_TOP_HI:`SMCD_ADDR_TOP_LO] == `SMCD_ADDR_TOP
      && !frame_reg[0][`SMCD_ADDR_RW_BIT]
      && frame_reg[0][`SMCD_ADDR_PIN_BIT] == pin_address_bit
      && (frame_reg[0][`SMCD_ADDR_NODE_HI:`SMCD_ADDR_NODE_LO] == node_addr || bcast);
   assign go = link.frame_end && addr_ok;
   assign first_target = {frame_reg[5], frame_reg[6]};

   // Byte collection, count saturates at nine
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= 4'h0;
      end
      else if (link.frame_end)
      begin
         count_reg <= 4'h0;
      end
      else if (link.byte_valid && count_reg != `SMCD_LEN_LONG)
      begin
         count_reg <= count_reg + 4'h1;
      end
   end

   // Byte storage, one generate entry per byte slot
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++)
      begin : g_byte
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               frame_reg[gi] <= 8'h00;
            end
            else if (link.byte_valid && count_reg == 4'(gi))
            begin
               frame_reg[gi] <= link.byte_data;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Frame length checks per command
   logic len_short;
   logic len_fuse;
   logic len_long;
   logic fill_ok;
   assign len_short = count_reg == `SMCD_LEN_SHORT;
   assign len_fuse = count_reg == `SMCD_LEN_FUSE;
   assign len_long = count_reg == `SMCD_LEN_LONG;
   assign fill_ok = frame_reg[2] == `SMCD_FILL && frame_reg[3] == `SMCD_FILL;

   logic do_safe, do_stop, do_zero, do_reload, do_run, do_dual, do_param, do_fuse;
   // Positioning commands blocked during dual sequence
   logic dual_busy;
   assign dual_busy = motion_state == smcd_pkg::SMCD_DUAL1
      || motion_state == smcd_pkg::SMCD_DUAL2;
   assign do_safe = go && len_short && cmd == `SMCD_CMD_SAFE && !dual_busy;
   assign do_stop = go && len_short && cmd == `SMCD_CMD_STOP && !bcast;
   assign do_zero = go && len_short && cmd == `SMCD_CMD_ZERO && !bcast;
   assign do_reload = go && len_short && cmd == `SMCD_CMD_RELOAD && !bcast;
   assign do_run = go && len_short && cmd == `SMCD_CMD_RUN && !bcast && !dual_busy;
   assign do_dual = go && len_long && fill_ok && cmd == `SMCD_CMD_DUAL && !bcast
      && !dual_busy;
   assign do_param = go && len_long && fill_ok && cmd == `SMCD_CMD_PARAM && !bcast;
   assign do_fuse = go && len_fuse && fill_ok && cmd == `SMCD_CMD_FUSE && !bcast
      && frame_reg[4][7:3] == 5'h1f;

   logic hard_stop; // Internal or commanded stop
   assign hard_stop = coil_fault || do_stop;

   // ==========================================================
   // Motion state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         motion_state <= smcd_pkg::SMCD_IDLE;
      end
      else if (coil_fault)
      begin
         motion_state <= smcd_pkg::SMCD_SHUT;
      end
      else if (do_stop)
      begin
         motion_state <= smcd_pkg::SMCD_IDLE;
      end
      else
      begin
         unique case (motion_state)
            smcd_pkg::SMCD_IDLE, smcd_pkg::SMCD_MOVE, smcd_pkg::SMCD_RUN:
            begin
               if (do_dual)
                  motion_state <= smcd_pkg::SMCD_DUAL1;
               else if (do_run)
                  motion_state <= smcd_pkg::SMCD_RUN;
               else if (do_safe)
                  motion_state <= smcd_pkg::SMCD_MOVE;
               else if (motion_done && motion_state == smcd_pkg::SMCD_MOVE)
                  motion_state <= smcd_pkg::SMCD_IDLE;
            end
            smcd_pkg::SMCD_DUAL1:
            begin
               // Second leg starts when motion_done ends the first leg
               if (motion_done)
                  motion_state <= smcd_pkg::SMCD_DUAL2;
            end
            smcd_pkg::SMCD_DUAL2:
            begin
               if (motion_done)
                  motion_state <= smcd_pkg::SMCD_IDLE;
            end
            smcd_pkg::SMCD_SHUT:
            begin
               // Leaves shutdown only by a commanded move or by a stop command
               if (do_safe)
                  motion_state <= smcd_pkg::SMCD_MOVE;
            end
            default:
               motion_state <= smcd_pkg::SMCD_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Actual position, signed sixteen bits
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         actual_position <= 16'h0000;
      else if (do_zero)
         actual_position <= 16'h0000;
      else if (actual_load)
         actual_position <= actual_in;
   end

   // Target position; reload leaves it alone
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         target_position <= 16'h0000;
      else if (do_zero)
         target_position <= 16'h0000;
      else if (hard_stop)
         target_position <= actual_position;
      else if (do_dual)
         target_position <= first_target;
      else if (motion_state == smcd_pkg::SMCD_DUAL1 && motion_done)
         target_position <= 16'(actual_position + second_offset);
      else if (do_safe)
         target_position <= {{5{safe_position[10]}}, safe_position};
   end

   // Missed-steps flag; a new stop wins over the clear
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         missed_steps_flag <= 1'b0;
      else if (hard_stop && moving)
         missed_steps_flag <= 1'b1;
      else if (clear_missed)
         missed_steps_flag <= 1'b0;
   end

   // ==========================================================
   // Motion settings, applied at once or reloaded
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         run_current <= `SMCD_RST_IRUN;
         hold_current <= `SMCD_RST_IHOLD;
         max_velocity <= `SMCD_RST_VMAX;
         min_velocity <= `SMCD_RST_VMIN;
         safe_position <= `SMCD_RST_SAFE;
         move_direction <= `SMCD_RST_DIR;
         acceleration <= `SMCD_RST_ACC;
         ramp_disable <= `SMCD_RST_RAMP;
         step_resolution <= `SMCD_RST_STEP;
      end
      else if (do_reload)
      begin
         run_current <= `SMCD_RST_IRUN;
         hold_current <= `SMCD_RST_IHOLD;
         max_velocity <= `SMCD_RST_VMAX;
         min_velocity <= `SMCD_RST_VMIN;
         safe_position <= `SMCD_RST_SAFE;
         move_direction <= `SMCD_RST_DIR;
         acceleration <= `SMCD_RST_ACC;
         ramp_disable <= `SMCD_RST_RAMP;
         step_resolution <= `SMCD_RST_STEP;
      end
      else if (do_param)
      begin
         run_current <= frame_reg[4][7:4];
         hold_current <= frame_reg[4][3:0];
         max_velocity <= frame_reg[5][7:4];
         min_velocity <= frame_reg[5][3:0];
         safe_position <= {frame_reg[6][7:5], frame_reg[7]};
         move_direction <= frame_reg[6][4];
         acceleration <= frame_reg[6][3:0];
         ramp_disable <= frame_reg[8][4];
         step_resolution <= frame_reg[8][3:2];
      end
      else if (do_dual)
      begin
         max_velocity <= frame_reg[4][7:4];
         min_velocity <= frame_reg[4][3:0];
      end
   end

   // Second offset held for the second leg
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         second_offset <= 16'h0000;
      else if (do_dual)
         second_offset <= {frame_reg[7], frame_reg[8]};
   end

   // ==========================================================
   // Fuse programming strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fuse_write <= 1'b0;
         fuse_cell_address <= 3'h0;
         fuse_data <= 8'h00;
      end
      else
      begin
         fuse_write <= do_fuse;
         if (do_fuse)
         begin
            fuse_cell_address <= frame_reg[4][2:0];
            fuse_data <= frame_reg[5];
         end
      end
   end
endmodule // smcd_device

// file: design/smcd_ctrl.sv
/*
 Controller end: builds a command frame from a user request and
 sends it one byte per cycle over the link.
 Assumes the user holds request fields stable while busy is high.
*/
`timescale 1ns/1ps
`include "smcd_defines.svh"
module smcd_ctrl (
   input wire logic clk,
   input wire logic rst_b,
   smcd_link_if.ctrl link,
   input wire logic req, // Pulse: send a frame
   input wire logic [7:0] req_cmd, // Command code
   input wire logic [3:0] req_node, // Node address bits
   input wire logic req_pin, // Addressed pin bit
   input wire logic [39:0] req_data, // Payload after fillers, first byte high
   output logic busy // Frame in progress
);
   // ==========================================================
   // Frame buffer and length
   logic [7:0] out_reg [0:8];
   logic [3:0] len_reg;
   logic [3:0] idx_reg;
   logic [3:0] len_next;

   // Frame length by command
   always_comb
   begin
      if (req_cmd == `SMCD_CMD_DUAL || req_cmd == `SMCD_CMD_PARAM)
         len_next = `SMCD_LEN_LONG;
      else if (req_cmd == `SMCD_CMD_FUSE)
         len_next = `SMCD_LEN_FUSE;
      else
         len_next = `SMCD_LEN_SHORT;
   end

   // Latch frame on request; address byte layout
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < 9; i++)
            out_reg[i] <= 8'h00;
         len_reg <= 4'h0;
      end
      else if (req && !busy)
      begin
         out_reg[0] <= {`SMCD_ADDR_TOP, req_node, req_pin, 1'b0};
         out_reg[1] <= req_cmd;
         out_reg[2] <= `SMCD_FILL;
         out_reg[3] <= `SMCD_FILL;
         for (int i = 0; i < 5; i++)
            out_reg[4 + i] <= req_data[39 - 8 * i -: 8];
         len_reg <= len_next;
      end
   end

   // Byte sequencer
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy <= 1'b0;
         idx_reg <= 4'h0;
         link.byte_valid <= 1'b0;
         link.byte_data <= 8'h00;
         link.frame_end <= 1'b0;
      end
      else
      begin
         link.frame_end <= 1'b0;
         link.byte_valid <= 1'b0;
         if (req && !busy)
         begin
            busy <= 1'b1;
            idx_reg <= 4'h0;
         end
         else if (busy && idx_reg < len_reg)
         begin
            link.byte_valid <= 1'b1;
            link.byte_data <= out_reg[idx_reg];
            idx_reg <= idx_reg + 4'h1;
         end
         else if (busy)
         begin
            link.frame_end <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule // smcd_ctrl

// file: test/smcd_link_sva.sv
/*
 Checker for the command byte link: address byte, fillers, frame lengths.
 Assumes one clock and the link signals handed in as plain inputs.
*/
`timescale 1ns/1ps
`include "smcd_defines.svh"
module smcd_link_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic frame_end
);
   logic [3:0] cnt_reg; // Bytes seen in this frame
   logic [7:0] cmd_reg; // Command byte of this frame
   // ==========================================================
   // Byte counter, cleared by the end pulse
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_reg <= 4'h0;
      else if (frame_end)
         cnt_reg <= 4'h0;
      else if (byte_valid)
         cnt_reg <= cnt_reg + 4'h1;
   end
   // Command byte capture
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cmd_reg <= 8'h0;
      else if (byte_valid && cnt_reg == 4'h1)
         cmd_reg <= byte_data;
   end
   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   addr_byte_a: assert property (byte_valid && cnt_reg == 4'h0 |->
      byte_data[7:6] == `SMCD_ADDR_TOP && !byte_data[0]) else $error("bad address byte");
   end_after_byte_a: assert property (frame_end |-> $past(byte_valid) && !byte_valid)
      else $error("frame end not after last byte");
   bytes_packed_a: assert property (byte_valid |=> byte_valid || frame_end)
      else $error("gap inside frame");
   short_len_a: assert property (frame_end && cmd_reg inside {8'h84, 8'h85, 8'h86, 8'h87,
      8'h97} |-> cnt_reg == `SMCD_LEN_SHORT) else $error("short frame length wrong");
   long_len_a: assert property (frame_end && cmd_reg inside {8'h88, 8'h89}
      |-> cnt_reg == `SMCD_LEN_LONG) else $error("long frame length wrong");
   fuse_len_a: assert property (frame_end && cmd_reg == `SMCD_CMD_FUSE
      |-> cnt_reg == `SMCD_LEN_FUSE) else $error("fuse frame length wrong");
   filler_a: assert property (byte_valid && cnt_reg inside {4'h2, 4'h3}
      |-> byte_data == `SMCD_FILL) else $error("filler byte wrong");
   fuse_addr_a: assert property (byte_valid && cnt_reg == 4'h4 && cmd_reg == `SMCD_CMD_FUSE
      |-> byte_data[7:3] == 5'h1f) else $error("fuse address byte wrong");
   param_tail_a: assert property (byte_valid && cnt_reg == 4'h8 && cmd_reg == `SMCD_CMD_PARAM
      |-> byte_data[7:5] == 3'h7 && byte_data[1:0] == 2'h3) else $error("settings tail wrong");
   // Main scenarios seen
   dual_c: cover property (frame_end && cmd_reg == `SMCD_CMD_DUAL);
   fuse_c: cover property (frame_end && cmd_reg == `SMCD_CMD_FUSE);
   stop_c: cover property (frame_end && cmd_reg == `SMCD_CMD_STOP);
endmodule // smcd_link_sva

// file: test/testbench.sv
/*
 Bench: controller end sends frames to the device end; a monitor compares
 device outputs after each frame end with queued expectations.
 Assumes the design files and smcd_defines.svh in the same compile.
*/
`timescale 1ns/1ps
`include "smcd_defines.svh"
module testbench;
   logic clk, rst_b, req, req_pin, coil_fault, motion_done, clear_missed, actual_load;
   logic [7:0] req_cmd;
   logic [3:0] req_node, node;
   logic [39:0] req_data;
   logic [15:0] actual_in, act, tgt, off, e_act, e_tgt, e_off, p1, p2;
   logic busy, flag, fw, dir, rd, e_flag, e_fw;
   smcd_pkg::smcd_motion_t st, st2, e_st;
   logic [3:0] rc, hc, vx, vn, ac, rc2;
   logic [10:0] sp, e_fuse;
   logic [1:0] sr;
   logic [2:0] fa;
   logic [7:0] fd;
   logic [34:0] e_set; // Expected settings, run current first
   logic [98:0] q[$]; // Expected snapshots, oldest first
   int fails, n_tests;
   smcd_link_if lk();
   smcd_link_if lk2(); // Second link, driven raw by the bench
   smcd_ctrl smcd_ctrl_inst (.clk(clk), .rst_b(rst_b), .link(lk.ctrl), .req(req),
      .req_cmd(req_cmd), .req_node(req_node), .req_pin(req_pin), .req_data(req_data), .busy(busy));
   smcd_device smcd_device_inst (.clk(clk), .rst_b(rst_b), .link(lk.dev), .node_addr(node),
      .pin_address_bit(req_pin), .coil_fault(coil_fault), .motion_done(motion_done),
      .clear_missed(clear_missed), .actual_in(actual_in), .actual_load(actual_load),
      .actual_position(act), .target_position(tgt), .missed_steps_flag(flag), .motion_state(st),
      .run_current(rc), .hold_current(hc), .max_velocity(vx), .min_velocity(vn),
      .safe_position(sp), .move_direction(dir), .acceleration(ac), .ramp_disable(rd),
      .step_resolution(sr), .second_offset(off), .fuse_write(fw), .fuse_cell_address(fa),
      .fuse_data(fd));
   smcd_device smcd_device_inst2 (.clk(clk), .rst_b(rst_b), .link(lk2.dev), .node_addr(node),
      .pin_address_bit(req_pin), .coil_fault(coil_fault), .motion_done(motion_done),
      .clear_missed(clear_missed), .actual_in(actual_in), .actual_load(actual_load),
      .actual_position(), .target_position(), .missed_steps_flag(), .motion_state(st2),
      .run_current(rc2), .hold_current(), .max_velocity(), .min_velocity(), .safe_position(),
      .move_direction(), .acceleration(), .ramp_disable(), .step_resolution(),
      .second_offset(), .fuse_write(), .fuse_cell_address(), .fuse_data());
   smcd_link_sva smcd_link_sva_inst (.clk(clk), .rst_b(rst_b), .byte_valid(lk.byte_valid),
      .byte_data(lk.byte_data), .frame_end(lk.frame_end));
   // ==========================================================
   // Snapshots and helpers
   function automatic logic [98:0] snap();
      snap = {act, tgt, st, flag, rc, hc, vx, vn, sp, dir, ac, rd, sr, off, fw,
         fw ? {fa, fd} : 11'h0};
   endfunction
   function automatic logic [98:0] expv();
      expv = {e_act, e_tgt, e_st, e_flag, e_set, e_off, e_fw, e_fuse};
   endfunction
   // Settings frame payload from the expected settings
   function automatic logic [39:0] pdat();
      pdat = {e_set[34:19], e_set[18:16], e_set[7:3], e_set[15:8], 3'h7, e_set[2:0], 2'h3};
   endfunction
   task automatic check(input logic [98:0] got, input logic [98:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t outputs %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Frame through the controller end, bounded wait on busy
   task automatic send(input logic [7:0] c, input logic [3:0] n, input logic [39:0] d);
      int i;
      q.push_back(expv());
      req_cmd = c;
      req_node = n;
      req_data = d;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      for (i = 0; i < 40 && (i < 2 || busy !== 1'b0); i++)
         @(negedge clk);
      if (busy !== 1'b0)
      begin
         fails++;
         stop_test();
      end
      repeat (2) @(negedge clk);
   endtask
   // Raw bytes on the second link, up to nine bytes
   task automatic raw(input logic [71:0] b, input int n);
      int i;
      for (i = 0; i < n; i++)
      begin
         lk2.byte_valid = 1'b1;
         lk2.byte_data = b[71-8*i -: 8];
         @(negedge clk);
      end
      lk2.byte_valid = 1'b0;
      lk2.byte_data = ~lk2.byte_data;
      lk2.frame_end = 1'b1;
      @(negedge clk);
      lk2.frame_end = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask
   // ==========================================================
   // Clock and result monitor
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk)
   begin
      if (lk.frame_end === 1'b1)
      begin
         @(negedge clk);
         if (q.size() == 0)
         begin
            fails++;
            $display("[FAIL] %0t result with no expectation", $time);
         end
         else
            check(snap(), q.pop_front());
      end
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      rst_b = 1'b0;
      {req, req_cmd, req_node, req_data, coil_fault, motion_done, clear_missed} = '0;
      {actual_in, actual_load, lk2.byte_valid, lk2.byte_data, lk2.frame_end} = '0;
      {e_act, e_tgt, e_off, e_flag, e_fw, e_fuse} = '0;
      e_st = smcd_pkg::SMCD_IDLE;
      e_set = {16'h0, `SMCD_RST_SAFE, 8'h0};
      void'($urandom(32'h83f1));
      node = 4'($urandom_range(15, 1));
      req_pin = 1'($urandom);
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      check(snap(), expv());
      // Long frame, unknown code, short settings frame, bad filler: all ignored
      raw({2'h3, node, req_pin, 1'b0, 8'h97, 8'hff, 48'h0}, 3);
      raw({2'h3, node, req_pin, 1'b0, 8'h8f, 56'h0}, 2);
      raw({2'h3, node, req_pin, 1'b0, 8'h89, 16'hffff, 8'hf0, 24'h0}, 6);
      raw({2'h3, node, req_pin, 1'b0, 8'h89, 16'hff7f, 8'hf0, 32'h0}, 9);
      check(99'({st2, rc2}), 99'({smcd_pkg::SMCD_IDLE, 4'h0}));
      raw({2'h3, node, req_pin, 1'b0, 8'h97, 56'h0}, 2);
      check(99'(st2), 99'(smcd_pkg::SMCD_RUN));
      e_set = {32'($urandom), 3'($urandom)};
      e_set[18] = 1'b0; // Safe position top bit clear
      send(`SMCD_CMD_PARAM, node, pdat());
      actual_in = 16'($urandom) | 16'h8000; // Negative position
      pulse(actual_load);
      e_act = actual_in;
      send(`SMCD_CMD_RUN, node ^ 4'h5, 40'h0);
      send(`SMCD_CMD_ZERO, `SMCD_BCAST_NODE, 40'h0);
      e_tgt = {5'h0, e_set[18:8]};
      e_st = smcd_pkg::SMCD_MOVE;
      send(`SMCD_CMD_SAFE, `SMCD_BCAST_NODE, 40'h0);
      e_tgt = e_act;
      e_st = smcd_pkg::SMCD_IDLE;
      e_flag = 1'b1;
      send(`SMCD_CMD_STOP, node, 40'h0);
      pulse(clear_missed);
      e_flag = 1'b0;
      check(snap(), expv());
      e_act = 16'h0;
      e_tgt = 16'h0;
      send(`SMCD_CMD_ZERO, node, 40'h0);
      e_st = smcd_pkg::SMCD_RUN;
      send(`SMCD_CMD_RUN, node, 40'h0);
      actual_in = 16'($urandom);
      pulse(actual_load);
      pulse(coil_fault);
      e_act = actual_in;
      e_tgt = actual_in;
      e_st = smcd_pkg::SMCD_SHUT;
      e_flag = 1'b1;
      check(snap(), expv());
      pulse(clear_missed);
      e_flag = 1'b0;
      e_tgt = {5'h0, e_set[18:8]};
      e_st = smcd_pkg::SMCD_MOVE;
      send(`SMCD_CMD_SAFE, node, 40'h0);
      pulse(motion_done);
      e_st = smcd_pkg::SMCD_IDLE;
      e_set = {16'h0, `SMCD_RST_SAFE, 8'h0};
      send(`SMCD_CMD_RELOAD, node, 40'h0);
      p1 = (e_act ^ 16'h8000) | 16'h4000; // Differs from actual and offset
      p2 = 16'($urandom_range(255, 1));
      e_tgt = p1;
      e_off = p2;
      e_st = smcd_pkg::SMCD_DUAL1;
      send(`SMCD_CMD_DUAL, node, {e_set[26:19], p1, p2});
      send(`SMCD_CMD_SAFE, node, 40'h0);
      e_set[26:23] = 4'($urandom);
      send(`SMCD_CMD_PARAM, node, pdat());
      actual_in = p1;
      pulse(actual_load);
      pulse(motion_done);
      e_act = p1;
      e_tgt = p1 + p2;
      e_st = smcd_pkg::SMCD_DUAL2;
      check(snap(), expv());
      pulse(motion_done);
      e_st = smcd_pkg::SMCD_IDLE;
      check(snap(), expv());
      e_fuse = 11'($urandom);
      e_fw = 1'b1;
      send(`SMCD_CMD_FUSE, node, {5'h1f, e_fuse, 24'h0});
      stop_test();
   end
endmodule // testbench
